// >>> hw/sbs_regs.vh
// Constants for the synchronous burst memory interface
`ifndef SBS_REGS_VH
`define SBS_REGS_VH
`define SBS_ADDR_W    10
`define SBS_LANES     4
`define SBS_LANE_W    9
`define SBS_BURST_W   2
`define SBS_ORDER_LIN 1'b0
`define SBS_ORDER_INT 1'b1
`endif

// >>> hw/sbs_mem.v
// Byte-lane memory array with registered read data
`timescale 1ns/1ns
module sbs_mem #(
	parameter AW    = 10,
	parameter LANES = 4,
	parameter LW    = 9
) (
	input  wire                clk_sys,
	input  wire [AW-1:0]       addr,
	input  wire                wr_en,
	input  wire [LANES-1:0]    lane_en,
	input  wire [LANES*LW-1:0] wdata,
	output reg  [LANES*LW-1:0] rdata_q
);
	reg [LANES*LW-1:0] mem [0:(1<<AW)-1];
	integer            i;

	always @(posedge clk_sys)
	begin
		if (wr_en)
		begin
			for (i = 0; i < LANES; i = i + 1)
			begin
				if (lane_en[i])
					mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
			end
		end
		rdata_q <= mem[addr];
	end
endmodule

// >>> hw/sbs_core.v
// Pipelined burst memory host interface: strobes, burst counter, writes, output control
// Notes on behaviour
// - Burst order strap low gives linear order, high gives interleaved order.
// - Every synchronous input is registered on the rising clock edge.
// - Read data leaves through output registers on the rising edge.
// - Two-bit wraparound counter holds burst start and makes remaining addresses.
// - Burst advance input alone steps the address; either strobe starts accesses.
// - Global write low writes all four lanes, ignoring byte enables.
// - Byte write updates only selected lanes, others stay unchanged.
// - Processor strobe ignored while first chip select is high.
// - Read starts on strobe low, all selects active, write enables high.
// - Read latches address; data drives bus after next edge if enabled.
// - First cycle after leaving deselect keeps outputs tri-stated regardless.
// - After the first cycle of a read, output enable alone controls the data pins.
// - Back-to-back single reads on consecutive cycles are accepted.
// - Deselect by chip selects with a strobe tri-states outputs at once.
// - Processor strobe write starts with selects active and loads address and burst.
// - First cycle of processor strobe write ignores write and advance inputs.
// - Processor strobe write completes on second edge using global or byte enables.
// - Data pins tri-state whenever a write cycle is detected.
// - Array writes are timed internally and synchronously to the clock.
// - Three synchronous chip selects and an asynchronous output enable.
// - With both strobes low and first chip select low, only the processor strobe is acted on.
// - Accepted strobe loads two lowest address bits as burst start.
`timescale 1ns/1ns
`include "sbs_regs.vh"
module sbs_core #(
	parameter AW    = `SBS_ADDR_W,
	parameter LANES = `SBS_LANES,
	parameter LW    = `SBS_LANE_W
) (
	input  wire                clk_sys,
	input  wire                rst_n,
	input  wire [AW-1:0]       addr,
	input  wire                chip_select_one_n,
	input  wire                chip_select_two,
	input  wire                chip_select_three_n,
	input  wire                processor_addr_strobe_n,
	input  wire                controller_addr_strobe_n,
	input  wire                burst_advance_n,
	input  wire                global_write_n,
	input  wire                byte_write_enable_n,
	input  wire [LANES-1:0]    byte_lane_select_n,
	input  wire                burst_order,
	input  wire                output_enable_n,
	input  wire [LANES*LW-1:0] data_in,
	output wire [LANES*LW-1:0] data_out,
	output wire                data_oe
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_READ  = 2'd1;
	localparam ST_PWR   = 2'd2;
	localparam ST_WRITE = 2'd3;

	// Input registers
	reg [AW-1:0]       addr_q;
	reg                cs1_n_q;
	reg                cs2_q;
	reg                cs3_n_q;
	reg                processor_addr_strobe_n_n_q;
	reg                controller_addr_strobe_n_n_q;
	reg                adv_n_q;
	reg                gw_n_q;
	reg                bwe_n_q;
	reg [LANES-1:0]    bw_n_q;
	reg [LANES*LW-1:0] din_q;
	reg                order_q;

	reg [1:0]          state_q;
	reg [1:0]          state_d;
	reg [AW-1:0]       base_q;
	reg [1:0]          cnt_q;
	reg                first_q;
	reg                rd_pipe_q;
	reg                drive_q;

	wire                sel_all;
	wire                take_p;
	wire                take_c;
	wire                take_any;
	wire                desel;
	wire                is_wr_req;
	wire [1:0]          low_bits;
	wire [AW-1:0]       mem_addr;
	wire                wr_en;
	wire [LANES-1:0]    lane_en;
	wire [LANES*LW-1:0] rdata;
	wire                adv_step;
	wire [1:0]          cnt_eff;
	wire                new_sel;
	wire                rd_next;
	wire                wr_ctl;
	wire                wr_proc;
	wire                oe_block;

	function [1:0] burst_low;
		input       ord;
		input [1:0] start;
		input [1:0] cnt;
		begin
			if (ord == `SBS_ORDER_INT)
				burst_low = start ^ cnt;
			else
				burst_low = start + cnt;
		end
	endfunction

	function [LANES-1:0] lanes_of;
		input             gw_n;
		input             bwe_n;
		input [LANES-1:0] bw_n;
		begin
			if (!gw_n)
				lanes_of = {LANES{1'b1}};
			else if (!bwe_n)
				lanes_of = ~bw_n;
			else
				lanes_of = {LANES{1'b0}};
		end
	endfunction

	// Register all synchronous inputs
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			addr_q   <= {AW{1'b0}};
			cs1_n_q  <= 1'b1;
			cs2_q    <= 1'b0;
			cs3_n_q  <= 1'b1;
			processor_addr_strobe_n_n_q <= 1'b1;
			controller_addr_strobe_n_n_q <= 1'b1;
			adv_n_q  <= 1'b1;
			gw_n_q   <= 1'b1;
			bwe_n_q  <= 1'b1;
			bw_n_q   <= {LANES{1'b1}};
			din_q    <= {(LANES*LW){1'b0}};
			order_q  <= `SBS_ORDER_INT;
		end
		else
		begin
			addr_q   <= addr;
			cs1_n_q  <= chip_select_one_n;
			cs2_q    <= chip_select_two;
			cs3_n_q  <= chip_select_three_n;
			processor_addr_strobe_n_n_q <= processor_addr_strobe_n;
			controller_addr_strobe_n_n_q <= controller_addr_strobe_n;
			adv_n_q  <= burst_advance_n;
			gw_n_q   <= global_write_n;
			bwe_n_q  <= byte_write_enable_n;
			bw_n_q   <= byte_lane_select_n;
			din_q    <= data_in;
			order_q  <= burst_order;
		end
	end

	assign sel_all   = !cs1_n_q && cs2_q && !cs3_n_q;
	assign take_p    = !processor_addr_strobe_n_n_q && !cs1_n_q;
	// Processor strobe wins only where it is not ignored
	assign take_c    = (processor_addr_strobe_n_n_q || cs1_n_q) && !controller_addr_strobe_n_n_q;
	assign take_any  = (take_p || take_c) && sel_all;
	assign desel     = (take_p || take_c) && !sel_all;
	assign is_wr_req = !gw_n_q || !bwe_n_q;
	// Advance counts on the edge that samples it, ahead of the array read
	assign adv_step  = !adv_n_q && !take_any && state_q != ST_IDLE && state_q != ST_PWR;
	assign cnt_eff   = adv_step ? cnt_q + 2'b01 : cnt_q;
	assign low_bits  = burst_low(order_q, base_q[1:0], cnt_eff);
	assign new_sel   = take_any && state_q == ST_IDLE;
	assign mem_addr  = take_any ? addr_q : {base_q[AW-1:2], low_bits};

	// Write issue: controller strobe writes now; processor strobe writes next cycle
	assign lane_en = (take_any && take_p) ? {LANES{1'b0}}
		: lanes_of(gw_n_q, bwe_n_q, bw_n_q);
	assign wr_ctl  = take_any && take_c && is_wr_req;
	assign wr_proc = !take_any && (state_q == ST_PWR || state_q == ST_WRITE)
		&& is_wr_req;
	assign wr_en   = wr_ctl || wr_proc;
	assign rd_next = !desel && !wr_en && (state_d == ST_READ
		|| (state_d == ST_PWR && !is_wr_req));

	// Access state
	always @*
	begin
		state_d = state_q;
		if (desel)
		begin
			state_d = ST_IDLE;
		end
		else if (take_p)
		begin
			state_d = ST_PWR;
		end
		else if (take_c)
		begin
			if (is_wr_req)
				state_d = ST_WRITE;
			else
				state_d = ST_READ;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					state_d = ST_IDLE;
				end
				ST_PWR:
				begin
					if (is_wr_req)
						state_d = ST_WRITE;
					else
						state_d = ST_READ;
				end
				ST_WRITE:
				begin
					if (is_wr_req)
						state_d = ST_WRITE;
					else
						state_d = ST_READ;
				end
				ST_READ:
				begin
					state_d = ST_READ;
				end
				default:
				begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Burst counter: a strobe reloads it, an advance steps it
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			base_q <= {AW{1'b0}};
			cnt_q  <= 2'b00;
		end
		else if (take_any)
		begin
			base_q <= addr_q;
			cnt_q  <= 2'b00;
		end
		else
		begin
			cnt_q <= cnt_eff;
		end
	end

	// Output flags, aligned with the registered read data
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			first_q   <= 1'b0;
			rd_pipe_q <= 1'b0;
			drive_q   <= 1'b0;
		end
		else
		begin
			first_q   <= new_sel;
			rd_pipe_q <= rd_next;
			drive_q   <= rd_next && !new_sel;
		end
	end

	sbs_mem #(
		.AW    (AW),
		.LANES (LANES),
		.LW    (LW)
	) u_mem (
		.clk_sys (clk_sys),
		.addr    (mem_addr),
		.wr_en   (wr_en),
		.lane_en (lane_en),
		.wdata   (din_q),
		.rdata_q (rdata)
	);

	assign data_out = rdata;
	// Asynchronous output enable, masked on first cycle, on writes and on deselect
	assign oe_block = first_q || !drive_q || state_q == ST_WRITE
		|| wr_en || desel;
	assign data_oe  = rd_pipe_q && !output_enable_n && !oe_block;
endmodule

// >>> verif/sbs_core_properties.sv
// Output drive assertions for the burst memory core
`timescale 1ns/1ns
module sbs_core_properties (
	input wire clk_sys,
	input wire rst_n,
	input wire chip_select_one_n,
	input wire processor_addr_strobe_n,
	input wire controller_addr_strobe_n,
	input wire global_write_n,
	input wire byte_write_enable_n,
	input wire output_enable_n,
	input wire data_oe
);
	wire p = !processor_addr_strobe_n;
	wire c = !controller_addr_strobe_n;
	wire s = !chip_select_one_n;
	wire w = !global_write_n || !byte_write_enable_n;
	wire r = (p || c) && s && !w;
	wire d = !s && c;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	oe_gate_a: assert property (data_oe |-> !output_enable_n)
		else $error("driven with enable off");
	rst_quiet_a: assert property (disable iff (1'b0) !rst_n |=> !data_oe)
		else $error("driven after reset");
	cwr_tri_a: assert property (c && !p && s && w |-> ##[1:2] !data_oe)
		else $error("driven in write");
	pwr_tri_a: assert property (p && s ##1 w && !p && !c |-> ##[0:2] !data_oe)
		else $error("driven in second write cycle");
	desel_tri_a: assert property (d |=> !data_oe)
		else $error("driven after deselect");
	idle_tri_a: assert property (d ##1 (!p && !c) [*3] |-> !data_oe)
		else $error("driven while idle");
	first_mask_a: assert property (d ##1 r |-> ##1 !data_oe [*2])
		else $error("driven in first cycle");
	read_drive_a: assert property (r [*4] ##1 !output_enable_n |-> data_oe)
		else $error("read not driven");
	cover property (r [*4]);
	cover property (d ##1 r);
	cover property (c && !p && s && w);
endmodule
bind sbs_core sbs_core_properties prop_u (.*);

// >>> verif/sbs_host_model.sv
// Cache controller model driving the burst bus
`timescale 1ns/1ns
module sbs_host_model (
	input  wire        clk_sys,
	output reg  [9:0]  addr,
	output reg         cs_n,
	output reg  [2:0]  stb,
	output reg  [5:0]  wr,
	output reg         oe_n,
	output reg  [35:0] din
);
	initial
		{addr, cs_n, stb, wr, oe_n, din} = {10'h0, 1'b0, 3'b111, 6'h3f, 1'b1, 36'h0};
	// Data lines toggle when no write data is due
	task cyc(input s, input [2:0] t, input [5:0] w, input [9:0] a, input [35:0] d);
		begin
			{cs_n, stb, wr, addr} = {s, t, w, a};
			oe_n = w != 6'h3f;
			din = oe_n ? d : ~din;
			@(negedge clk_sys);
		end
	endtask
endmodule

// >>> verif/sbs_core_tb_top.sv
// Self-checking bench for the burst memory core
`timescale 1ns/1ns
module sbs_core_tb_top;
	reg         clk_sys, rst_n, ord;
	reg  [35:0] m [0:3];
	wire [9:0]  a;
	wire [2:0]  stb;
	wire [5:0]  wr;
	wire        cs_n, oe_n, data_oe;
	wire [35:0] din, dout;
	integer     fail_count, n_tests, i;
	sbs_host_model host_u (.clk_sys(clk_sys), .addr(a), .cs_n(cs_n), .stb(stb), .wr(wr),
		.oe_n(oe_n), .din(din));
	sbs_core dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .addr(a), .chip_select_one_n(cs_n),
		.chip_select_two(1'b1), .chip_select_three_n(1'b0), .burst_order(ord),
		.processor_addr_strobe_n(stb[2]), .controller_addr_strobe_n(stb[1]),
		.burst_advance_n(stb[0]), .global_write_n(wr[5]), .byte_write_enable_n(wr[4]),
		.byte_lane_select_n(wr[3:0]), .output_enable_n(oe_n), .data_in(din),
		.data_out(dout), .data_oe(data_oe));
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task chk(input [31:0] nm, input [35:0] got, input [35:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp)
			begin
				fail_count = fail_count + 1;
				$display("mismatch %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task stop_test;
		begin
			$display("%0d checks, %0d mismatches", n_tests, fail_count);
			if (fail_count == 0 && n_tests > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task rst(input o);
		begin
			rst_n = 1'b0;
			ord = o;
			repeat (3) @(negedge clk_sys);
			rst_n = 1'b1;
			for (i = 0; i < 4; i = i + 1)
			begin
				m[i] = {4{9'h0a5 + i[8:0]}};
				host_u.cyc(1'b0, 3'b101, 6'h0f, 10'h004 + i[9:0], m[i]);
			end
		end
	endtask
	// Strobe reads or one burst, checked two edges behind
	task pipe(input bst, input [1:0] s);
		reg [1:0] k;
		begin
			for (i = 0; i < 6; i = i + 1)
			begin
				k = ord ? s ^ i[1:0] : s + i[1:0];
				if (i == 0 || (!bst && i < 4))
					host_u.cyc(1'b0, 3'b101, 6'h3f, {8'h01, k}, 36'h0);
				else
					host_u.cyc(1'b0, {2'b11, !(bst && i < 4)}, 6'h3f, 10'h0, 36'h0);
				k = ord ? s ^ (i[1:0] - 2'd1) : s + i[1:0] - 2'd1;
				if (i > 0 && i < 5)
					chk("pipe", dout, m[k]);
			end
			$display("pipe test done");
		end
	endtask
	initial
	begin
		fail_count = 0;
		n_tests = 0;
		rst(1'b1);
		host_u.cyc(1'b0, 3'b101, 6'h2a, 10'h005, 36'h0);
		m[1] = m[1] & ~36'h007fc01ff;
		host_u.cyc(1'b0, 3'b011, 6'h00, 10'h006, 36'hfffffffff);
		host_u.cyc(1'b0, 3'b111, 6'h2c, 10'h0, 36'h123456789);
		m[2] = {m[2][35:18], 18'h16789};
		pipe(1'b1, 2'd2);
		pipe(1'b0, 2'd1);
		host_u.cyc(1'b1, 3'b001, 6'h3f, 10'h007, 36'h0);
		host_u.cyc(1'b0, 3'b101, 6'h3f, 10'h005, 36'h0);
		host_u.cyc(1'b0, 3'b111, 6'h3f, 10'h0, 36'h0);
		chk("oe", {35'h0, data_oe}, 36'h0);
		chk("rd", dout, m[1]);
		host_u.cyc(1'b0, 3'b111, 6'h3f, 10'h0, 36'h0);
		chk("oe", {35'h0, data_oe}, 36'h1);
		$display("deselect test done");
		rst(1'b0);
		pipe(1'b1, 2'd3);
		stop_test;
	end
	initial
	begin
		#2000;
		fail_count = fail_count + 1;
		stop_test;
	end
endmodule
